// file: rtl/power_path_map.svh
// Register offsets, field positions, reset values and timing counts of the power path selector
`ifndef POWER_PATH_MAP_SVH
`define POWER_PATH_MAP_SVH

`define PP_ADDR_W 4
`define PP_OFF_CONFIG 4'h0
`define PP_OFF_WAIT 4'h1
`define PP_OFF_STATUS 4'h2
`define PP_OFF_OVFLAG 4'h3

// charge_config_reg fields
`define CFG_OVERRIDE_BIT 0
`define CFG_SUSPEND_BIT 1
`define CFG_USB_HIGH_BIT 2
`define CFG_SRC_SEL_BIT 3
`define CFG_CHG_ON_BIT 4
`define CFG_RESET 8'h1d

// Converter wait register: pack id current select field
`define WAIT_ID_LSB 0
`define WAIT_ID_W 2
`define WAIT_RESET 8'h00

// Overvoltage flag register fields
`define OV_AC_BIT 0
`define OV_USB_BIT 1

// Current limit codes
`define ILIM_100MA 2'h0
`define ILIM_500MA 2'h1
`define ILIM_2750MA 2'h2

// Timing: boot hold 100 ms, no-pack deglitch 2 ms, clock 40 ns
`define CLK_PERIOD_NS 40
`define BOOT_HOLD_MS 100
`define NOPACK_DGL_US 2000
`define BOOT_HOLD_CYC (`BOOT_HOLD_MS * 1000000 / `CLK_PERIOD_NS)
`define NOPACK_DGL_CYC (`NOPACK_DGL_US * 1000 / `CLK_PERIOD_NS)

`endif

// file: rtl/power_path_pkg.sv
// Types shared by the power path selector
package power_path_pkg;

    typedef struct packed {
        logic acPresent;
        logic usbPresent;
        logic acOverVolt;
        logic usbOverVolt;
        logic supplementNeed;
        logic outShort;
        logic batShort;
        logic noPack;
        logic thermalShutdown;
        logic chargeAtZero;
        logic inputShort;
    } sense_t;

    typedef struct packed {
        logic acSwitchOn;
        logic usbSwitchOn;
        logic batSwitchOn;
        logic inOutPullupOn;
        logic batOutPullupOn;
        logic dischargeOn;
        logic chargeEnable;
        logic chargeReduce;
        logic packIdSourceOn;
        logic [1:0] packIdCurrent;
        logic [1:0] inputLimit;
    } drive_t;

    typedef enum {
        SRC_BATTERY,
        SRC_AC,
        SRC_USB,
        SRC_BREAK
    } src_t;

endpackage

// file: rtl/power_path_selector.sv
// Power path source selection, protection and boot hold with an Avalon-MM register slave
// Notes on behaviour
// RULE_01 - Input connected only while above battery
// RULE_02 - Bus below battery flags supplement need
// RULE_03 - Lost input falls to next priority
// RULE_04 - Override high: AC first, then USB
// RULE_05 - Override high: battery on only for supplement
// RULE_06 - Override low: inputs open, battery closed
// RULE_07 - Forced battery never reconnects inputs
// RULE_08 - Path state readable in status register
// RULE_09 - USB limit decoded from two bits
// RULE_10 - AC limit always fixed internal value
// RULE_11 - Overload: reduce charge, then supplement
// RULE_12 - Input overvoltage sets status bit
// RULE_13 - Overvoltage leaves input switches unchanged
// RULE_14 - Thermal shutdown opens inputs, closes battery
// RULE_15 - Output short opens inputs, enables pullups
// RULE_16 - Battery short opens battery switch, pullup
// RULE_17 - Boot period ignores bits, USB limit 100 mA
// RULE_18 - After boot apply host settings
// RULE_19 - Pack id source on unless sleeping
// RULE_20 - Pack id current from wait register
// RULE_21 - Deglitched no-pack enables discharge switch
// RULE_22 - Overload handled in two stages
// RULE_23 - Second stage closes battery switch
// RULE_24 - Comparators pass two-flop synchroniser
// RULE_25 - AC and USB never closed together
`timescale 1ns/1ps
`include "power_path_map.svh"

module power_path_selector
    import power_path_pkg::*;
#(
    parameter int BOOT_CYCLES = `BOOT_HOLD_CYC,
    parameter int DGL_CYCLES = `NOPACK_DGL_CYC
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [`PP_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic sleepMode,
    input wire sense_t senseAsync,
    output drive_t drive
);

    sense_t sync1_r;
    sense_t sense_r;
    logic [7:0] config_r;
    logic [7:0] wait_r;
    logic [1:0] ovFlag_r;
    logic ackDone_r;
    logic booting_r;
    logic [31:0] bootCount_r;
    logic [31:0] dglCount_r;
    logic packGone_r;
    src_t src_r;
    src_t src_nxt;
    logic overrideEff;
    logic usbHighEff;
    logic srcSelEff;
    logic chargeOnEff;
    logic suspendEff;
    logic inputsBlocked;
    logic [7:0] statusWord;

    function automatic logic [1:0] usb_limit(input logic srcSel, input logic highSel);
        if (srcSel)
            usb_limit = `ILIM_2750MA;
        else if (highSel)
            usb_limit = `ILIM_500MA;
        else
            usb_limit = `ILIM_100MA;
    endfunction

    // First flop feeds only the second one
    always_ff @(posedge mclk)
    begin
        sync1_r <= senseAsync; // see RULE_24
        sense_r <= sync1_r; // see RULE_24
    end

    // One wait state per access: simple, and reads always return settled data
    always_ff @(posedge mclk)
    begin
        if (reset)
            ackDone_r <= 1'b0;
        else if ((read || write) && !ackDone_r)
            ackDone_r <= 1'b1;
        else
            ackDone_r <= 1'b0;
    end
    assign waitrequest = (read || write) && !ackDone_r;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            config_r <= `CFG_RESET;
            wait_r <= `WAIT_RESET;
        end
        else if (write && ackDone_r)
        begin
            if (address == `PP_OFF_CONFIG)
                config_r <= writedata[7:0];
            if (address == `PP_OFF_WAIT)
                wait_r <= writedata[7:0];
        end
    end

    // Overvoltage flags: set wins over write-one-to-clear
    always_ff @(posedge mclk)
    begin
        if (reset)
            ovFlag_r <= 2'h0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (write && ackDone_r && address == `PP_OFF_OVFLAG && writedata[i])
                    ovFlag_r[i] <= 1'b0;
            end
            if (sense_r.acOverVolt)
                ovFlag_r[`OV_AC_BIT] <= 1'b1; // see RULE_12
            if (sense_r.usbOverVolt)
                ovFlag_r[`OV_USB_BIT] <= 1'b1; // see RULE_12
        end
    end

    assign statusWord = {packGone_r, sense_r.supplementNeed, drive.batSwitchOn,
        drive.usbSwitchOn, drive.acSwitchOn, booting_r, src_r == SRC_USB, src_r == SRC_AC};

    always_ff @(posedge mclk)
    begin
        if (reset)
            readdata <= 32'h0;
        else if (read && !ackDone_r)
        begin
            case (address)
                `PP_OFF_CONFIG: readdata <= {24'h0, config_r};
                `PP_OFF_WAIT: readdata <= {24'h0, wait_r};
                `PP_OFF_STATUS: readdata <= {24'h0, statusWord}; // see RULE_08
                `PP_OFF_OVFLAG: readdata <= {30'h0, ovFlag_r};
                default: readdata <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            booting_r <= 1'b1;
            bootCount_r <= 32'h0;
        end
        else if (booting_r)
        begin
            if (bootCount_r >= 32'(BOOT_CYCLES - 1))
                booting_r <= 1'b0; // see RULE_18
            bootCount_r <= bootCount_r + 32'h1;
        end
    end

    // Boot hold forces charger on, override on and USB 100 mA
    assign overrideEff = booting_r ? 1'b1 : config_r[`CFG_OVERRIDE_BIT]; // see RULE_17
    assign usbHighEff = booting_r ? 1'b0 : config_r[`CFG_USB_HIGH_BIT]; // see RULE_17
    assign srcSelEff = booting_r ? 1'b0 : config_r[`CFG_SRC_SEL_BIT]; // see RULE_17
    assign suspendEff = booting_r ? 1'b0 : config_r[`CFG_SUSPEND_BIT]; // see RULE_17
    assign chargeOnEff = booting_r ? 1'b1 : config_r[`CFG_CHG_ON_BIT];

    // Deglitch: any drop of the comparator restarts the count
    always_ff @(posedge mclk)
    begin
        if (reset || !sense_r.noPack)
        begin
            dglCount_r <= 32'h0;
            packGone_r <= 1'b0;
        end
        else if (dglCount_r >= 32'(DGL_CYCLES - 1))
            packGone_r <= 1'b1; // see RULE_21
        else
            dglCount_r <= dglCount_r + 32'h1;
    end

    // Overvoltage is deliberately absent here so closed switches stay closed
    assign inputsBlocked = !overrideEff || sense_r.thermalShutdown // see RULE_13
        || sense_r.outShort;

    always_comb
    begin
        src_nxt = SRC_BATTERY;
        if (inputsBlocked)
            src_nxt = SRC_BATTERY; // see RULE_06 RULE_07 RULE_14 RULE_15
        else if (sense_r.acPresent)
            src_nxt = SRC_AC; // see RULE_01 RULE_04
        else if (sense_r.usbPresent)
            src_nxt = SRC_USB; // see RULE_01 RULE_03 RULE_04
        else
            src_nxt = SRC_BATTERY; // see RULE_03
        // Switch between inputs goes through one open cycle
        if ((src_r == SRC_AC && src_nxt == SRC_USB) || (src_r == SRC_USB && src_nxt == SRC_AC))
            src_nxt = SRC_BREAK; // see RULE_25
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            src_r <= SRC_BATTERY;
        else
            src_r <= src_nxt;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            drive <= '0;
        else
        begin
            drive.acSwitchOn <= src_nxt == SRC_AC; // see RULE_25
            drive.usbSwitchOn <= src_nxt == SRC_USB; // see RULE_25
            if (sense_r.batShort)
                drive.batSwitchOn <= 1'b0; // see RULE_16
            else if (src_nxt == SRC_AC || src_nxt == SRC_USB)
                drive.batSwitchOn <= sense_r.supplementNeed // see RULE_02 RULE_05 RULE_11
                    || (sense_r.chargeAtZero && sense_r.inputShort); // see RULE_22 RULE_23
            else
                drive.batSwitchOn <= 1'b1; // see RULE_06 RULE_14
            drive.inOutPullupOn <= sense_r.outShort; // see RULE_15
            drive.batOutPullupOn <= sense_r.batShort; // see RULE_16
            drive.dischargeOn <= packGone_r; // see RULE_21
            drive.chargeEnable <= chargeOnEff && !suspendEff;
            drive.chargeReduce <= sense_r.inputShort; // see RULE_11 RULE_22
            drive.packIdSourceOn <= !sleepMode; // see RULE_19
            drive.packIdCurrent <= wait_r[`WAIT_ID_LSB +: `WAIT_ID_W]; // see RULE_20
            if (src_nxt == SRC_AC)
                drive.inputLimit <= `ILIM_2750MA; // see RULE_10
            else
                drive.inputLimit <= usb_limit(srcSelEff, usbHighEff); // see RULE_09 RULE_17
        end
    end

    property p_never_both;
        @(posedge mclk) disable iff (reset) !(drive.acSwitchOn && drive.usbSwitchOn);
    endproperty
    a_never_both: assert property (p_never_both) else $error("AC and USB closed"); // see RULE_25

    property p_override_low;
        @(posedge mclk) disable iff (reset)
            (!overrideEff && !sense_r.batShort) |=> (!drive.acSwitchOn && !drive.usbSwitchOn
            && drive.batSwitchOn);
    endproperty
    a_override_low: assert property (p_override_low) else $error("no battery"); // see RULE_06

    property p_ac_priority;
        @(posedge mclk) disable iff (reset)
            (!inputsBlocked && sense_r.acPresent && src_r == SRC_AC) |=> drive.acSwitchOn;
    endproperty
    a_ac_priority: assert property (p_ac_priority) else $error("AC not selected"); // see RULE_04

    property p_usb_only;
        @(posedge mclk) disable iff (reset)
            (!inputsBlocked && !sense_r.acPresent && sense_r.usbPresent && src_r != SRC_AC)
            |=> drive.usbSwitchOn;
    endproperty
    a_usb_only: assert property (p_usb_only) else $error("USB not selected"); // see RULE_03

    property p_thermal;
        @(posedge mclk) disable iff (reset)
            (sense_r.thermalShutdown && !sense_r.batShort) |=> (drive.batSwitchOn
            && !drive.acSwitchOn && !drive.usbSwitchOn);
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal ignored"); // see RULE_14

    property p_out_short;
        @(posedge mclk) disable iff (reset)
            sense_r.outShort |=> (drive.inOutPullupOn && !drive.acSwitchOn && !drive.usbSwitchOn);
    endproperty
    a_out_short: assert property (p_out_short) else $error("short missed"); // see RULE_15

    property p_bat_short;
        @(posedge mclk) disable iff (reset)
            sense_r.batShort |=> (!drive.batSwitchOn && drive.batOutPullupOn);
    endproperty
    a_bat_short: assert property (p_bat_short) else $error("battery short missed"); // see RULE_16

    property p_boot_limit;
        @(posedge mclk) disable iff (reset)
            (booting_r && !drive.acSwitchOn && $past(booting_r))
            |-> drive.inputLimit == `ILIM_100MA;
    endproperty
    a_boot_limit: assert property (p_boot_limit) else $error("boot limit wrong"); // see RULE_17

    property p_ov_flag;
        @(posedge mclk) disable iff (reset)
            sense_r.acOverVolt |=> ovFlag_r[`OV_AC_BIT];
    endproperty
    a_ov_flag: assert property (p_ov_flag) else $error("AC flag missing"); // see RULE_12

    property p_discharge;
        @(posedge mclk) disable iff (reset)
            !sense_r.noPack |=> ##1 !drive.dischargeOn;
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge stuck on"); // see RULE_21

    property p_ac_limit;
        @(posedge mclk) disable iff (reset)
            drive.acSwitchOn |-> drive.inputLimit == `ILIM_2750MA;
    endproperty
    a_ac_limit: assert property (p_ac_limit) else $error("AC limit wrong"); // see RULE_10

    property p_sleep_off;
        @(posedge mclk) disable iff (reset)
            sleepMode |=> !drive.packIdSourceOn;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("id source on"); // see RULE_19

    property p_awake_on;
        @(posedge mclk) disable iff (reset)
            !sleepMode |=> drive.packIdSourceOn;
    endproperty
    a_awake_on: assert property (p_awake_on) else $error("id source off"); // see RULE_19

    property p_id_cur;
        @(posedge mclk) disable iff (reset)
            1'b1 |=> drive.packIdCurrent == $past(wait_r[`WAIT_ID_LSB +: `WAIT_ID_W]);
    endproperty
    a_id_cur: assert property (p_id_cur) else $error("id current wrong"); // see RULE_20

    property p_boot_chg;
        @(posedge mclk) disable iff (reset)
            booting_r |=> drive.chargeEnable;
    endproperty
    a_boot_chg: assert property (p_boot_chg) else $error("charger off in boot"); // see RULE_17

    // The break cycle closes the battery as well, so supplement holds through it
    property p_supp;
        @(posedge mclk) disable iff (reset)
            (sense_r.supplementNeed && !sense_r.batShort && !inputsBlocked
            && (sense_r.acPresent || sense_r.usbPresent)) |=> drive.batSwitchOn;
    endproperty
    a_supp: assert property (p_supp) else $error("no supplement"); // see RULE_02

    property p_no_supp;
        @(posedge mclk) disable iff (reset)
            (!inputsBlocked && sense_r.acPresent && src_r != SRC_USB && !sense_r.supplementNeed
            && !(sense_r.chargeAtZero && sense_r.inputShort)) |=> !drive.batSwitchOn;
    endproperty
    a_no_supp: assert property (p_no_supp) else $error("battery closed idle"); // see RULE_05

    property p_reduce;
        @(posedge mclk) disable iff (reset)
            sense_r.inputShort |=> drive.chargeReduce;
    endproperty
    a_reduce: assert property (p_reduce) else $error("no charge reduce"); // see RULE_11

    property p_ov_usb;
        @(posedge mclk) disable iff (reset)
            sense_r.usbOverVolt |=> ovFlag_r[`OV_USB_BIT];
    endproperty
    a_ov_usb: assert property (p_ov_usb) else $error("USB flag missing"); // see RULE_12

    // Checked on the switch outputs so a change of state coding cannot hide an overlap
    property p_usb_bbm;
        @(posedge mclk) disable iff (reset)
            $rose(drive.usbSwitchOn) |-> !$past(drive.acSwitchOn);
    endproperty
    a_usb_bbm: assert property (p_usb_bbm) else $error("USB made before break"); // see RULE_25

    property p_ac_bbm;
        @(posedge mclk) disable iff (reset)
            $rose(drive.acSwitchOn) |-> !$past(drive.usbSwitchOn);
    endproperty
    a_ac_bbm: assert property (p_ac_bbm) else $error("AC made before break"); // see RULE_25

    property p_pack_gone;
        @(posedge mclk) disable iff (reset)
            packGone_r |=> drive.dischargeOn;
    endproperty
    a_pack_gone: assert property (p_pack_gone) else $error("discharge not on"); // see RULE_21

    property p_pullup_off;
        @(posedge mclk) disable iff (reset)
            !sense_r.outShort |=> !drive.inOutPullupOn;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pullup stuck"); // see RULE_15

    c_supp: cover property (@(posedge mclk) disable iff (reset)
        drive.acSwitchOn && drive.batSwitchOn);
    c_ac_sel: cover property (@(posedge mclk) disable iff (reset) drive.acSwitchOn);
    c_usb_sel: cover property (@(posedge mclk) disable iff (reset) drive.usbSwitchOn);
    c_break: cover property (@(posedge mclk) disable iff (reset) src_r == SRC_BREAK);
    c_boot_end: cover property (@(posedge mclk) disable iff (reset) $fell(booting_r));

endmodule

// file: tb/source_model.sv
// Behavioural comparator bank for the adapter, USB port and battery pack
`timescale 1ns/1ps
module source_model
    import power_path_pkg::*;
#(
    parameter int OVP_MV = 6500,
    parameter int OUTSH_MV = 1500,
    parameter int BATSH_MV = 300,
    parameter int REG_MV = 4400
)
(
    input wire logic mclk,
    input wire logic [15:0] acMv,
    input wire logic [15:0] usbMv,
    input wire logic [15:0] batMv,
    input wire logic [15:0] outMv,
    input wire logic idHigh,
    input wire logic hot,
    input wire logic chgZero,
    output sense_t senseAsync
);
    // Levels move just after the edge so the selector sees them as true async inputs
    always_ff @(posedge mclk)
    begin
        senseAsync.acPresent <= acMv > batMv;
        senseAsync.usbPresent <= usbMv > batMv;
        senseAsync.acOverVolt <= acMv > OVP_MV;
        senseAsync.usbOverVolt <= usbMv > OVP_MV;
        senseAsync.supplementNeed <= outMv < batMv;
        senseAsync.outShort <= outMv < OUTSH_MV;
        senseAsync.batShort <= outMv + BATSH_MV < batMv;
        senseAsync.noPack <= idHigh;
        senseAsync.thermalShutdown <= hot;
        senseAsync.chargeAtZero <= chgZero;
        senseAsync.inputShort <= outMv < REG_MV;
    end
endmodule

// file: tb/tb.sv
// Self-checking bench for the power path selector
`timescale 1ns/1ps
`include "power_path_map.svh"
module tb
    import power_path_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic sleepMode = 1'b0;
    sense_t senseAsync;
    drive_t drive;
    logic [15:0] acMv = 16'h0;
    logic [15:0] usbMv = 16'h1388;
    logic [15:0] batMv = 16'he74;
    logic [15:0] outMv = 16'h11f8;
    logic idHigh = 1'b0;
    logic hot = 1'b0;
    logic chgZero = 1'b0;
    int n_fail = 0;
    int checks = 0;
    logic [31:0] rd;
    logic [7:0] cfgs [4] = '{8'h11, 8'h15, 8'h19, 8'h1d};
    logic [1:0] lims [4] = '{2'h0, 2'h1, 2'h2, 2'h2};

    always #20 mclk = ~mclk;

    power_path_selector #(.BOOT_CYCLES(20), .DGL_CYCLES(8)) dut_u (
        .mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .sleepMode(sleepMode), .senseAsync(senseAsync), .drive(drive));

    source_model src_u (
        .mclk(mclk), .acMv(acMv), .usbMv(usbMv), .batMv(batMv), .outMv(outMv),
        .idHigh(idHigh), .hot(hot), .chgZero(chgZero), .senseAsync(senseAsync));

    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low at an edge, then released
    task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        @(posedge mclk iff waitrequest === 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Model edge plus two sync flops plus drive register, with margin for the break cycle
    task automatic settle();
        repeat (6) @(posedge mclk);
    endtask

    task automatic path(input logic [2:0] exp);
        chk({29'h0, drive.acSwitchOn, drive.usbSwitchOn, drive.batSwitchOn}, {29'h0, exp});
    endtask

    initial
    begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        settle();
        chk({30'h0, drive.inputLimit}, {30'h0, `ILIM_100MA});
        chk({31'h0, drive.chargeEnable}, 32'h1);
        access(1'b1, `PP_OFF_CONFIG, 32'h1e);
        rchk(`PP_OFF_STATUS, 32'h16);
        path(3'b010);
        chk({30'h0, drive.inputLimit}, {30'h0, `ILIM_100MA});
        chk({31'h0, drive.chargeEnable}, 32'h1);
        rchk(`PP_OFF_CONFIG, 32'h1e);
        repeat (20) @(posedge mclk);
        path(3'b001);
        chk({31'h0, drive.chargeEnable}, 32'h0);
        chk({30'h0, drive.inputLimit}, {30'h0, `ILIM_2750MA});
        acMv <= 16'h1388;
        settle();
        path(3'b001);
        batMv <= 16'h0;
        settle();
        path(3'b001);
        batMv <= 16'he74;
        access(1'b1, `PP_OFF_CONFIG, 32'h1d);
        settle();
        path(3'b100);
        chk({30'h0, drive.inputLimit}, {30'h0, `ILIM_2750MA});
        rchk(`PP_OFF_STATUS, 32'h09);
        access(1'b1, `PP_OFF_STATUS, 32'hff);
        rchk(`PP_OFF_STATUS, 32'h09);
        rchk(4'h4, 32'h0);
        acMv <= 16'h0;
        settle();
        path(3'b010);
        for (int i = 0; i < 4; i++)
        begin
            access(1'b1, `PP_OFF_CONFIG, {24'h0, cfgs[i]});
            settle();
            chk({30'h0, drive.inputLimit}, {30'h0, lims[i]});
        end
        usbMv <= 16'h0;
        settle();
        path(3'b001);
        acMv <= 16'h1388;
        settle();
        path(3'b100);
        outMv <= 16'he10;
        chgZero <= 1'b1;
        settle();
        path(3'b101);
        chk({31'h0, drive.chargeReduce}, 32'h1);
        outMv <= 16'h11f8;
        chgZero <= 1'b0;
        acMv <= 16'h1b58;
        usbMv <= 16'h1b58;
        settle();
        path(3'b100);
        rchk(`PP_OFF_OVFLAG, 32'h03);
        acMv <= 16'h1388;
        usbMv <= 16'h0;
        // Clear only after the comparators have dropped, since a standing fault wins
        settle();
        access(1'b1, `PP_OFF_OVFLAG, 32'h03);
        rchk(`PP_OFF_OVFLAG, 32'h00);
        hot <= 1'b1;
        settle();
        path(3'b001);
        hot <= 1'b0;
        outMv <= 16'h3e8;
        settle();
        chk({30'h0, drive.acSwitchOn, drive.usbSwitchOn}, 32'h0);
        chk({31'h0, drive.inOutPullupOn}, 32'h1);
        outMv <= 16'hbb8;
        settle();
        chk({30'h0, drive.batSwitchOn, drive.batOutPullupOn}, 32'h1);
        outMv <= 16'h11f8;
        settle();
        path(3'b100);
        idHigh <= 1'b1;
        repeat (4) @(posedge mclk);
        idHigh <= 1'b0;
        settle();
        chk({31'h0, drive.dischargeOn}, 32'h0);
        idHigh <= 1'b1;
        repeat (16) @(posedge mclk);
        chk({31'h0, drive.dischargeOn}, 32'h1);
        access(1'b1, `PP_OFF_WAIT, 32'h02);
        rchk(`PP_OFF_WAIT, 32'h02);
        settle();
        chk({30'h0, drive.packIdCurrent}, 32'h2);
        chk({31'h0, drive.packIdSourceOn}, 32'h1);
        sleepMode <= 1'b1;
        settle();
        chk({31'h0, drive.packIdSourceOn}, 32'h0);
        results();
    end

    // The sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        results();
    end
endmodule
